//--- src/dfl_pkg.sv
package dfl_pkg;
  // ==========================================
  // Link geometry
  localparam int DFL_WORD_W = 16;
  localparam int DFL_LANE_W = 8;
  localparam int DFL_FIFO_DEPTH = 8;
  // ==========================================
  // Timing: system clock and link clock divider
  localparam int DFL_CLK_PERIOD_PS = 5000;
  localparam int DFL_HALF_DIV = 2;
  localparam int DFL_DIV_W = 2;
  // Lock wait after board reset release, in ns
  localparam int DFL_LOCK_NS = 100;
  localparam int DFL_LOCK_CYC = (DFL_LOCK_NS * 1000 + DFL_CLK_PERIOD_PS - 1) / DFL_CLK_PERIOD_PS;
  // Receive near-full threshold in free entries
  localparam int DFL_NEAR_FREE = 32;
  localparam int DFL_RX_DEPTH = 64;
endpackage : dfl_pkg

//--- src/dfl_link_if.sv
`timescale 1ns/1ps
interface dfl_link_if #(parameter int LANE_W = 8);
  logic link_forward_clock;
  logic [LANE_W-1:0] link_ddr_bus;
  logic parcel_valid_flag;
  logic receiver_near_full;
  logic far_side_reset_b;
  modport tx (output link_forward_clock, output link_ddr_bus, output parcel_valid_flag,
    output far_side_reset_b, input receiver_near_full);
  modport rx (input link_forward_clock, input link_ddr_bus, input parcel_valid_flag,
    input far_side_reset_b, output receiver_near_full);
endinterface : dfl_link_if

//--- src/dfl_fifo.sv
`timescale 1ns/1ps
module dfl_fifo
  import dfl_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] free_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire [AW:0] used = wr_ptr - rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // ==========================================
  // Status; full stalls the filling side
  assign in_ready = (used != DEPTH[AW:0]);
  assign out_valid = (used != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign free_count = DEPTH[AW:0] - used;
  // Pointer update
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // Storage carries no reset
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : dfl_fifo

//--- src/dfl_tx.sv
`timescale 1ns/1ps
module dfl_tx
  import dfl_pkg::*;
#(
  parameter int WORD_W = DFL_WORD_W,
  parameter int DEPTH = DFL_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic board_reset_in_b,
  input wire logic lock_in,
  input wire logic loop_clock_in,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WORD_W-1:0] wr_data,
  output logic tx_ready,
  output logic clock_aligned,
  dfl_link_if.tx link
);
  localparam int LW = WORD_W / 2;
  wire rst_b = board_reset_in_b;

  // ==========================================
  // Timing overview, in system clock cycles after a period start edge E
  //   E    link clock rises; word popped; low half registered
  //   E+1  low half and flag reach the pins, one cycle behind the clock
  //   E+2  link clock falls; high half registered; flag cleared
  //   E+3  high half reaches the pins; flag stays low through phase 1
  //   E+4  next period start
  // The one-cycle lag buys hold margin at the receiver; it adds a cycle of
  // latency but costs no throughput.

  // ==========================================
  // Lock tracking: internal lock counter and external lock both required
  // Lock comes from outside this domain, so two flops come first; the counter
  // adds a minimum wait even when lock is already high at reset release
  logic [$clog2(DFL_LOCK_CYC+1)-1:0] lock_cnt;
  logic lock_s1;
  logic lock_s2;
  wire locked = (lock_cnt == DFL_LOCK_CYC[$bits(lock_cnt)-1:0]) && lock_s2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt <= '0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
    end else begin
      lock_s1 <= lock_in;
      lock_s2 <= lock_s1;
      if (!(lock_cnt == DFL_LOCK_CYC[$bits(lock_cnt)-1:0])) lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // Far reset follows board reset and lock; registered to avoid glitches
  logic far_reset_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) far_reset_b <= 1'b0;
    else far_reset_b <= locked;
  end
  assign link.far_side_reset_b = far_reset_b;

  // ==========================================
  // Near-full synchroniser; first flop read only by second
  // Resets high so the link counts as not ready until told otherwise
  logic nf_s1;
  logic nf_s2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nf_s1 <= 1'b1;
      nf_s2 <= 1'b1;
    end else begin
      nf_s1 <= link.receiver_near_full;
      nf_s2 <= nf_s1;
    end
  end

  // Ready only once far end released and receiver drops near-full
  // Sticky until board reset; a later near-full only pauses sending
  logic started;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) started <= 1'b0;
    else if (far_reset_b && !nf_s2) started <= 1'b1;
  end
  assign tx_ready = started;

  // ==========================================
  // Loopback clock sampled; phase agreement shown as status
  // Both sides of the compare carry two flops of delay, so only skew on the
  // board path shows up as a disagreement
  logic lb_s1;
  logic lb_s2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lb_s1 <= 1'b0;
      lb_s2 <= 1'b0;
    end else begin
      lb_s1 <= loop_clock_in;
      lb_s2 <= lb_s1;
    end
  end

  // ==========================================
  // Transmit buffer
  // Writes while full are refused through wr_ready; the writer holds its word
  logic f_valid;
  logic f_pop;
  logic [WORD_W-1:0] f_data;
  dfl_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_buf (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data),
    .free_count()
  );

  // ==========================================
  // Divider: half period of DFL_HALF_DIV cycles, even duty
  // Phase resets to 1 so the first half_end opens a phase 0
  logic [DFL_DIV_W-1:0] div_cnt;
  logic phase;
  wire half_end = (div_cnt == DFL_DIV_W'(DFL_HALF_DIV - 1));
  wire period_start = half_end && phase; // Next half is phase 0
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      phase <= 1'b1;
    end else if (half_end) begin
      div_cnt <= '0;
      phase <= ~phase;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  // Clock high in phase 0, one flop ahead of data below
  logic fclk;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) fclk <= 1'b0;
    else if (half_end) fclk <= phase;
  end

  // ==========================================
  // Word fetch at period start; gated by flow control
  // Idle periods drive zeros so nothing stale leaves the chip
  wire send = period_start && started && f_valid && !nf_s2;
  assign f_pop = send;
  logic [LW-1:0] hi_half;
  logic [LW-1:0] bus_q;
  logic flag_q;
  logic fclk_d;
  // Half-period data registers; fclk_d keeps clock history for the loop compare
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fclk_d <= 1'b0;
      bus_q <= '0;
      flag_q <= 1'b0;
      hi_half <= '0;
    end else begin
      fclk_d <= fclk;
      if (period_start) begin
        hi_half <= send ? f_data[WORD_W-1:LW] : '0;
        bus_q <= send ? f_data[LW-1:0] : '0;
        flag_q <= send;
      end else if (half_end) begin
        bus_q <= hi_half;
        flag_q <= 1'b0;
      end
    end
  end
  // Data and flag reach the pins one cycle after the link clock edge
  logic [LW-1:0] bus_o;
  logic flag_o;
  logic fclk_d2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_o <= '0;
      flag_o <= 1'b0;
      fclk_d2 <= 1'b0;
    end else begin
      bus_o <= bus_q;
      flag_o <= flag_q;
      fclk_d2 <= fclk_d;
    end
  end
  // Loopback agrees when it matches the clock sent two cycles earlier
  assign clock_aligned = (lb_s2 == fclk_d2);
  // Link clock leaves straight from its flop, ahead of the data flops
  assign link.link_forward_clock = fclk;
  assign link.link_ddr_bus = bus_o;
  assign link.parcel_valid_flag = flag_o;
endmodule : dfl_tx

//--- src/dfl_rx.sv
`timescale 1ns/1ps
module dfl_rx
  import dfl_pkg::*;
#(
  parameter int WORD_W = DFL_WORD_W,
  parameter int DEPTH = DFL_RX_DEPTH,
  parameter int NEAR_FREE = DFL_NEAR_FREE
) (
  input wire logic clock,
  input wire logic rst_b,
  dfl_link_if.rx link,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WORD_W-1:0] rd_data,
  output logic local_reset_b
);
  localparam int LW = WORD_W / 2;
  // ==========================================
  // Far reset synchroniser: local logic held while asserted
  logic rr_s1;
  logic rr_s2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rr_s1 <= 1'b0;
      rr_s2 <= 1'b0;
    end else begin
      rr_s1 <= link.far_side_reset_b;
      rr_s2 <= rr_s1;
    end
  end
  wire lrst_b = rr_s2;
  assign local_reset_b = lrst_b;
  // ==========================================
  // Link pins sampled through two flops
  logic c1, c2, c3;
  logic f1, f2;
  logic [LW-1:0] b1, b2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      c1 <= 1'b0;
      c2 <= 1'b0;
      c3 <= 1'b0;
      f1 <= 1'b0;
      f2 <= 1'b0;
      b1 <= '0;
      b2 <= '0;
    end else begin
      c1 <= link.link_forward_clock;
      c2 <= c1;
      c3 <= c2;
      f1 <= link.parcel_valid_flag;
      f2 <= f1;
      b1 <= link.link_ddr_bus;
      b2 <= b1;
    end
  end
  // Only rising edge is used; fall would be skew-sensitive
  wire rise = c2 && !c3;
  // ==========================================
  // Phase 0 capture one cycle after rise, phase 1 one half-period (two cycles) later
  logic [1:0] tick;
  logic armed;
  logic [LW-1:0] lo_half;
  logic push;
  logic [WORD_W-1:0] word;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick <= '0;
      armed <= 1'b0;
      lo_half <= '0;
      push <= 1'b0;
      word <= '0;
    end else begin
      push <= 1'b0;
      if (rise) begin
        tick <= 2'h1;
      end else if (tick != 2'h0) begin
        tick <= tick + 2'h1;
      end
      if (tick == 2'h1) begin
        armed <= f2 && lrst_b;
        lo_half <= b2;
      end
      if (tick == 2'h3 && armed) begin
        word <= {b2, lo_half};
        push <= 1'b1;
        armed <= 1'b0;
      end
    end
  end
  // ==========================================
  // Receive buffer and near-full back-pressure
  logic [$clog2(DEPTH):0] free;
  dfl_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_buf (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(),
    .in_data(word),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .free_count(free)
  );
  // Near-full also stands in reset to signal not ready
  logic nf;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) nf <= 1'b1;
    else nf <= !lrst_b || (free <= NEAR_FREE[$bits(free)-1:0]);
  end
  assign link.receiver_near_full = nf;
endmodule : dfl_rx

//--- tb/dfl_link_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Link protocol checker
module dfl_link_monitor
  import dfl_pkg::*;
#(
  parameter int LANE_W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_forward_clock,
  input wire logic [LANE_W-1:0] link_ddr_bus,
  input wire logic parcel_valid_flag,
  input wire logic receiver_near_full,
  input wire logic far_side_reset_b
);
  logic fclk_q;
  logic [7:0] since_rst;
  // Last link clock level, and cycles since reset (saturates so it never wraps)
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fclk_q <= 1'b0;
      since_rst <= 8'h00;
    end else begin
      fclk_q <= link_forward_clock;
      if (since_rst != 8'hff) since_rst <= since_rst + 8'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_half_period;
    $changed(link_forward_clock) |=> $stable(link_forward_clock) ##1 $changed(link_forward_clock);
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("link clock half period is not two cycles");
  property p_flag_phase;
    parcel_valid_flag |-> $past(link_forward_clock);
  endproperty
  a_flag_phase: assert property (p_flag_phase)
    else $error("flag seen outside phase 0");
  property p_flag_shape;
    $rose(parcel_valid_flag) |=> parcel_valid_flag ##1 !parcel_valid_flag ##1 !parcel_valid_flag;
  endproperty
  a_flag_shape: assert property (p_flag_shape)
    else $error("flag pulse is not one full phase");
  property p_lead;
    $rose(parcel_valid_flag) |-> $past(link_forward_clock) && !$past(link_forward_clock, 2);
  endproperty
  a_lead: assert property (p_lead)
    else $error("flag did not trail the link clock rise");
  // Bus may only switch one cycle after a link clock edge
  property p_bus_switch;
    $changed(link_ddr_bus) |-> $past(link_forward_clock) != $past(fclk_q);
  endproperty
  a_bus_switch: assert property (p_bus_switch)
    else $error("bus switched away from a half period boundary");
  // Eight cycles cover the two-flop sync plus the fetch-to-flag delay
  property p_near_full;
    receiver_near_full [*8] |-> !$rose(parcel_valid_flag);
  endproperty
  a_near_full: assert property (p_near_full)
    else $error("parcel started while receiver near full");
  property p_reset_idle;
    !far_side_reset_b |-> !parcel_valid_flag && receiver_near_full;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link active while far side held in reset");
  property p_lock_wait;
    $rose(far_side_reset_b) |-> since_rst >= DFL_LOCK_CYC;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("far reset released before lock wait");
endmodule : dfl_link_monitor

//--- tb/ddr_forwarded_clock_link_tb.sv
`timescale 1ns/1ps
module ddr_forwarded_clock_link_tb
  import dfl_pkg::*;
;
  typedef struct packed {logic [15:0] w; logic [15:0] e;} dfl_row_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic lock_in = 1'b0;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic rd_ready = 1'b0;
  logic wr_ready, tx_ready, clock_aligned, rd_valid, local_reset_b;
  logic [15:0] rd_data, word;
  logic [15:0] sq[$], rq[$], wq[$];
  int err_count = 0;
  int total_checks = 0;
  int k, n;
  dfl_row_t rows[4] = '{'{16'h0000, 16'h0000}, '{16'hffff, 16'hffff},
    '{16'ha5c3, 16'ha5c3}, '{16'h0001, 16'h0001}};
  dfl_link_if #(.LANE_W(DFL_LANE_W)) link ();
  always #2.5 clock = ~clock;
  // ==========================================
  // Both ends face each other; link clock is looped back into the sender
  dfl_tx dfl_tx_inst (.clock(clock), .board_reset_in_b(rst_b), .lock_in(lock_in),
    .loop_clock_in(link.link_forward_clock), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .tx_ready(tx_ready), .clock_aligned(clock_aligned), .link(link));
  dfl_rx dfl_rx_inst (.clock(clock), .rst_b(rst_b), .link(link), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .local_reset_b(local_reset_b));
  dfl_link_monitor #(.LANE_W(DFL_LANE_W)) dfl_link_monitor_inst (.clock(clock), .rst_b(rst_b),
    .link_forward_clock(link.link_forward_clock), .link_ddr_bus(link.link_ddr_bus),
    .parcel_valid_flag(link.parcel_valid_flag), .receiver_near_full(link.receiver_near_full),
    .far_side_reset_b(link.far_side_reset_b));
  // Words taken from the receive port
  always @(posedge clock) if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
  // Rebuild words from the wire: the flagged half carries the low byte
  always begin
    @(negedge clock);
    if (link.parcel_valid_flag === 1'b1) begin
      word[7:0] = link.link_ddr_bus;
      repeat (2) @(negedge clock);
      word[15:8] = link.link_ddr_bus;
      wq.push_back(word);
      @(negedge clock);
    end
  end
  // ==========================================
  // Check and report helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // Bounded wait for the receive port; running out counts as a mismatch
  task automatic wait_rq(input int cnt);
    n = 0;
    while (rq.size() < cnt && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n == 4000) begin
      $display("[ERR] rx_wait expected %0d seen %0d", cnt, rq.size());
      err_count++;
      results();
    end
  endtask : wait_rq
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    chk("far_rst", 16'h0, {15'h0, link.far_side_reset_b});
    chk("near_full", 16'h1, {15'h0, link.receiver_near_full});
    rst_b = 1'b1;
    repeat (40) @(negedge clock);
    chk("far_rst_nolock", 16'h0, {15'h0, link.far_side_reset_b});
    chk("tx_ready_early", 16'h0, {15'h0, tx_ready});
    lock_in = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("far_rst_up", 16'h1, {15'h0, link.far_side_reset_b});
    chk("local_rst", 16'h1, {15'h0, local_reset_b});
    chk("tx_ready", 16'h1, {15'h0, tx_ready});
    chk("clock_aligned", 16'h1, {15'h0, clock_aligned});
    if (tx_ready !== 1'b1) results();
    $display("reset test done");
    // Table rows sent back to back
    rd_ready = 1'b1;
    wr_valid = 1'b1;
    foreach (rows[i]) begin
      wr_data = rows[i].w;
      n = 0;
      while (wr_ready !== 1'b1 && n < 400) begin
        @(negedge clock);
        n++;
      end
      if (n == 400) begin
        chk("wr_ready_wait", 16'h1, {15'h0, wr_ready});
        results();
      end
      sq.push_back(rows[i].e);
      @(negedge clock);
    end
    wr_valid = 1'b0;
    wait_rq(4);
    foreach (rows[i]) chk("row", rows[i].e, rq[i]);
    $display("row test done");
    // Stalled reader: fill until the sender refuses for 200 cycles
    rd_ready = 1'b0;
    wr_valid = 1'b1;
    k = 0;
    n = 0;
    while (n < 200 && k < 200) begin
      wr_data = 16'h1000 + 16'(k);
      if (wr_ready === 1'b1) begin
        sq.push_back(wr_data);
        k++;
        n = 0;
      end else n++;
      @(negedge clock);
    end
    wr_valid = 1'b0;
    chk("near_full_stall", 16'h1, {15'h0, link.receiver_near_full});
    chk("wr_ready_full", 16'h0, {15'h0, wr_ready});
    chk("fill_min", 16'h1, {15'h0, k >= 40});
    chk("fill_max", 16'h1, {15'h0, k <= 72});
    rd_ready = 1'b1;
    wait_rq(sq.size());
    foreach (sq[i]) begin
      chk("rx_word", sq[i], rq[i]);
      chk("wire_word", sq[i], wq[i]);
    end
    chk("wire_count", 16'(sq.size()), 16'(wq.size()));
    $display("stall test done");
    results();
  end
endmodule : ddr_forwarded_clock_link_tb
